// ===== imub_map.svh
// register offsets, field positions, reset values for the upper interrupt mask block
// assumes an axi4-lite slave with 32-bit data, one register per aligned word
// Overview of operation
// RL1 - mask bit 0 blocks its event source, mask bit 1 lets it interrupt
// RL2 - mid byte bit 7 gates mode change, bit 6 gates main reference failure
// RL3 - mid byte bits 0 to 5 gate reference inputs nine to fourteen
// RL4 - high byte bit 7 gates the frame sync input alarm
// RL5 - high byte bit 6 gates secondary loop status, bit 5 phase monitor alarm
// RL6 - high byte bit 4 gates failure of all secondary loop inputs
// RL7 - high byte bit 3 gates line code violation on line input two
// RL8 - high byte bit 2 gates loss of signal on line input two
// RL9 - both mask bytes read and write, and reset to zero
// RL10 - high byte bit 1 gates violation, bit 0 loss of signal, line input one
// RL11 - interrupt request high while any pending event is enabled
`ifndef IMUB_MAP_SVH
`define IMUB_MAP_SVH
`define IMUB_ADDR_W         8
`define IMUB_OFF_MID        8'h44
`define IMUB_OFF_HIGH       8'h48
`define IMUB_OFF_PEND_MID   8'h4c
`define IMUB_OFF_PEND_HIGH  8'h50
`define IMUB_OFF_IRQ        8'h54
`define IMUB_RST_MASK       8'h00
`define IMUB_BIT_MODE       7
`define IMUB_BIT_MAIN_FAIL  6
`define IMUB_BIT_REF9       0
`define IMUB_BIT_REF14      5
`define IMUB_BIT_SYNC       7
`define IMUB_BIT_SEC_STATE  6
`define IMUB_BIT_PHASE      5
`define IMUB_BIT_SEC_LOST   4
`define IMUB_BIT_LC2_VIOL   3
`define IMUB_BIT_LC2_LOS    2
`define IMUB_BIT_LC1_VIOL   1
`define IMUB_BIT_LC1_LOS    0
`define IMUB_RESP_OKAY      2'b00
`define IMUB_RESP_SLVERR    2'b10
`endif

// ===== imub_pkg.sv
// types for the upper interrupt mask block
// assumes imub_map.svh is compiled alongside
package imub_pkg;
    typedef struct packed {
        logic       mode_change;
        logic       main_ref_fail;
        logic [5:0] ref_nine_to_fourteen;
    } imub_mid_type;
    typedef struct packed {
        logic frame_pulse_input_alert;
        logic secondary_loop_state;
        logic phase_alarm;
        logic secondary_sources_lost;
        logic line_code2_violation;
        logic line_code2_signal_loss;
        logic line_code1_violation;
        logic line_code1_signal_loss;
    } imub_high_type;
    typedef struct packed {
        imub_high_type high;
        imub_mid_type  mid;
    } imub_events_type;
    typedef enum logic [1:0] {
        IMUB_IDLE,
        IMUB_RESP
    } imub_wstate_type;
endpackage

// ===== imub_gate.sv
// per-bit gating of pending events by the mask, reduced to one request
// assumes pending and mask come from registers in the same clock domain
`timescale 1ns/1ps
module imub_gate (
    input  wire logic [15:0] pend_i,
    input  wire logic [15:0] mask_i,
    output logic      [15:0] gated_o,
    output logic             req_o
);
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : gbit
            assign gated_o[g] = pend_i[g] & mask_i[g]; // RL1
        end
    endgenerate
    assign req_o = |gated_o; // RL11
endmodule

// ===== imub_top.sv
// upper interrupt mask bytes with axi4-lite slave and interrupt request
// assumes EVENT_I is a level from the event status logic, synchronous to CLK_I
`timescale 1ns/1ps
`include "imub_map.svh"
module imub_top (
    input  wire logic                         CLK_I,
    input  wire logic                         RESETN_I,
    input  wire imub_pkg::imub_events_type    EVENT_I,
    output logic                              IRQ_O,
    input  wire logic [`IMUB_ADDR_W-1:0]      AWADDR_I,
    input  wire logic                         AWVALID_I,
    output logic                              AWREADY_O,
    input  wire logic [31:0]                  WDATA_I,
    input  wire logic [3:0]                   WSTRB_I,
    input  wire logic                         WVALID_I,
    output logic                              WREADY_O,
    output logic [1:0]                        BRESP_O,
    output logic                              BVALID_O,
    input  wire logic                         BREADY_I,
    input  wire logic [`IMUB_ADDR_W-1:0]      ARADDR_I,
    input  wire logic                         ARVALID_I,
    output logic                              ARREADY_O,
    output logic [31:0]                       RDATA_O,
    output logic [1:0]                        RRESP_O,
    output logic                              RVALID_O,
    input  wire logic                         RREADY_I
);
    imub_pkg::imub_mid_type   mid_q;
    imub_pkg::imub_high_type  high_q;
    logic [`IMUB_ADDR_W-1:0]  awaddr_q;
    logic                     aw_have_q;
    logic [31:0]              wdata_q;
    logic                     wstrb0_q;
    logic                     w_have_q;
    logic                     bvalid_q;
    logic [1:0]               bresp_q;
    logic                     rvalid_q;
    logic [31:0]              rdata_q;
    logic [1:0]               rresp_q;
    logic                     irq_q;
    logic [15:0]              gated;
    logic                     req;

    // write address and data taken independently, response once both are held
    wire aw_take   = AWVALID_I & ~aw_have_q & ~bvalid_q;
    wire w_take    = WVALID_I & ~w_have_q & ~bvalid_q;
    wire do_write  = aw_have_q & w_have_q & ~bvalid_q;
    wire sel_mid   = (awaddr_q == `IMUB_OFF_MID);
    wire sel_high  = (awaddr_q == `IMUB_OFF_HIGH);
    wire wr_ok     = sel_mid | sel_high;
    wire wr_mid    = do_write & sel_mid & wstrb0_q;
    wire wr_high   = do_write & sel_high & wstrb0_q;
    wire [15:0] mask_all = {high_q, mid_q};

    assign AWREADY_O = ~aw_have_q & ~bvalid_q;
    assign WREADY_O  = ~w_have_q & ~bvalid_q;
    assign BVALID_O  = bvalid_q;
    assign BRESP_O   = bresp_q;

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            aw_have_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (aw_take) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= AWADDR_I;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            w_have_q <= 1'b0;
            wdata_q  <= '0;
            wstrb0_q <= 1'b0;
        end else if (w_take) begin
            w_have_q <= 1'b1;
            wdata_q  <= WDATA_I;
            wstrb0_q <= WSTRB_I[0];
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `IMUB_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? `IMUB_RESP_OKAY : `IMUB_RESP_SLVERR;
        end else if (BREADY_I) begin
            bvalid_q <= 1'b0;
        end
    end

    // mask bytes
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mid_q  <= `IMUB_RST_MASK; // RL9
            high_q <= `IMUB_RST_MASK; // RL9
        end else begin
            if (wr_mid) begin
                mid_q <= wdata_q[7:0]; // RL2 RL3
            end
            if (wr_high) begin
                high_q <= wdata_q[7:0]; // RL4 RL5 RL6 RL7 RL8 RL10
            end
        end
    end

    // read channel
    wire ar_take = ARVALID_I & ~rvalid_q;
    wire [7:0] rd_byte =
        (ARADDR_I == `IMUB_OFF_MID)       ? mid_q :
        (ARADDR_I == `IMUB_OFF_HIGH)      ? high_q :
        (ARADDR_I == `IMUB_OFF_PEND_MID)  ? EVENT_I.mid :
        (ARADDR_I == `IMUB_OFF_PEND_HIGH) ? EVENT_I.high :
        (ARADDR_I == `IMUB_OFF_IRQ)       ? {7'h00, irq_q} : 8'h00;
    wire rd_ok = (ARADDR_I == `IMUB_OFF_MID) | (ARADDR_I == `IMUB_OFF_HIGH) |
                 (ARADDR_I == `IMUB_OFF_PEND_MID) | (ARADDR_I == `IMUB_OFF_PEND_HIGH) |
                 (ARADDR_I == `IMUB_OFF_IRQ);

    assign ARREADY_O = ~rvalid_q;
    assign RVALID_O  = rvalid_q;
    assign RDATA_O   = rdata_q;
    assign RRESP_O   = rresp_q;

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `IMUB_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte}; // RL9
            rresp_q  <= rd_ok ? `IMUB_RESP_OKAY : `IMUB_RESP_SLVERR;
        end else if (RREADY_I) begin
            rvalid_q <= 1'b0;
        end
    end

    // event gating and request
    imub_gate imub_gate_i (
        .pend_i  (EVENT_I),
        .mask_i  (mask_all),
        .gated_o (gated),
        .req_o   (req)
    );

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= req; // RL11
        end
    end

    assign IRQ_O = irq_q;
endmodule

// ===== imub_chk_checker.sv
// port checks for the upper interrupt mask block
// assumes binding to imub_top, one clock domain
`timescale 1ns/1ps
module imub_chk (
    input wire logic                      CLK_I,
    input wire logic                      RESETN_I,
    input wire imub_pkg::imub_events_type EVENT_I,
    input wire logic                      IRQ_O,
    input wire logic                      AWVALID_I,
    input wire logic                      AWREADY_O,
    input wire logic                      WVALID_I,
    input wire logic                      WREADY_O,
    input wire logic                      BVALID_O,
    input wire logic                      BREADY_I,
    input wire logic                      ARVALID_I,
    input wire logic                      ARREADY_O,
    input wire logic                      RVALID_O,
    input wire logic                      RREADY_I,
    input wire logic [31:0]               RDATA_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    property p_irq; EVENT_I == '0 |=> !IRQ_O; endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_wr; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O; endproperty
    a_wr: assert property (p_wr) else $error("no bvalid");
    property p_bdr; BVALID_O && BREADY_I |=> !BVALID_O; endproperty
    a_bdr: assert property (p_bdr) else $error("bvalid");
    property p_rd; ARVALID_I && ARREADY_O |=> RVALID_O; endproperty
    a_rd: assert property (p_rd) else $error("no rvalid");
    property p_rdr; RVALID_O && RREADY_I |=> !RVALID_O; endproperty
    a_rdr: assert property (p_rdr) else $error("rvalid");
    property p_arb; RVALID_O |-> !ARREADY_O; endproperty
    a_arb: assert property (p_arb) else $error("arready");
    property p_awb; BVALID_O |-> !AWREADY_O && !WREADY_O; endproperty
    a_awb: assert property (p_awb) else $error("awready");
    property p_up; RVALID_O |-> RDATA_O[31:8] == '0; endproperty
    a_up: assert property (p_up) else $error("upper");
    property p_bhold; BVALID_O && !BREADY_I |=> BVALID_O; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold; RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O); endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");
    property p_irqsrc; IRQ_O |-> $past(EVENT_I) != '0; endproperty
    a_irqsrc: assert property (p_irqsrc) else $error("irq without event");
endmodule
bind imub_top imub_chk imub_chk_i (.*);

// ===== imub_host.sv
// axi4-lite host model with write and read tasks
// assumes one clock, tasks called from the bench
`timescale 1ns/1ps
module imub_host (
    input  wire logic        clk_i,
    output logic [7:0]       awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic [31:0]      wdata_o,
    output logic [3:0]       wstrb_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic [1:0]  bresp_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    output logic [7:0]       araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  rresp_i,
    input  wire logic        rvalid_i,
    output logic             rready_o
);
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        wrs(a, d, 4'hf, r);
    endtask
    task wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge clk_i);
        {awaddr_o, wdata_o, wstrb_o} <= {a, d, s};
        {awvalid_o, wvalid_o, bready_o} <= 3'h7;
        do begin
            @(posedge clk_i);
            if (awready_i) awvalid_o <= 1'b0;
            if (wready_i) wvalid_o <= 1'b0;
        end while (!bvalid_i);
        r = bresp_i;
        bready_o <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        {araddr_o, arvalid_o, rready_o} <= {a, 2'h3};
        do begin
            @(posedge clk_i);
            if (arready_i) arvalid_o <= 1'b0;
        end while (!rvalid_i);
        {d, r} = {rdata_i, rresp_i};
        rready_o <= 1'b0;
    endtask
endmodule

// ===== interrupt_mask_upper_bits_bench.sv
// self-checking bench for the upper interrupt mask block
// assumes imub_host drives the register bus
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; $display("Error %0t got %h", $time, a); end end
module interrupt_mask_upper_bits_bench;
    logic        CLK_I, RESETN_I, AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
    logic        ARVALID_I, ARREADY_O, RVALID_O, RREADY_I, IRQ_O;
    logic [7:0]  AWADDR_I, ARADDR_I;
    logic [31:0] WDATA_I, RDATA_O, d;
    logic [3:0]  WSTRB_I;
    logic [1:0]  BRESP_O, RRESP_O, r;
    imub_pkg::imub_events_type EVENT_I;
    int          bad_count, check_count, cyc, i;
    imub_top imub_top_i (.*);
    imub_host imub_host_i (.clk_i(CLK_I), .awaddr_o(AWADDR_I), .awvalid_o(AWVALID_I), .awready_i(AWREADY_O),
        .wdata_o(WDATA_I), .wstrb_o(WSTRB_I), .wvalid_o(WVALID_I), .wready_i(WREADY_O), .bresp_i(BRESP_O),
        .bvalid_i(BVALID_O), .bready_o(BREADY_I), .araddr_o(ARADDR_I), .arvalid_o(ARVALID_I),
        .arready_i(ARREADY_O), .rdata_i(RDATA_O), .rresp_i(RRESP_O), .rvalid_i(RVALID_O), .rready_o(RREADY_I));
    initial begin
        CLK_I = 1'b0;
        forever #2.5 CLK_I = ~CLK_I;
    end
    always @(posedge CLK_I) begin
        if (++cyc == 6000) begin
            bad_count++;
            end_sim;
        end
    end
    task end_sim;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task ev(input logic [15:0] e, input logic x);
        @(posedge CLK_I);
        EVENT_I <= e;
        repeat (2) @(posedge CLK_I);
        #1 `CHK(IRQ_O, x)
    endtask
    initial begin
        RESETN_I = 1'b0;
        EVENT_I = '0;
        repeat (8) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        imub_host_i.rd(8'h44, d, r); `CHK(d, 32'h0)
        imub_host_i.rd(8'h48, d, r); `CHK(d, 32'h0)
        ev(16'hffff, 1'b0);
        for (i = 0; i < 16; i++) begin
            imub_host_i.wr(i < 8 ? 8'h44 : 8'h48, 32'h1 << (i % 8), r); `CHK(r, 2'b00)
            ev(16'h1 << i, 1'b1);
            ev(~(16'h1 << i), 1'b0);
            imub_host_i.wr(i < 8 ? 8'h44 : 8'h48, 32'h0, r);
        end
        imub_host_i.wr(8'h48, 32'h80, r);
        ev(16'h8001, 1'b1);
        imub_host_i.rd(8'h4c, d, r); `CHK(d, 32'h01)
        imub_host_i.rd(8'h50, d, r); `CHK(d, 32'h80)
        imub_host_i.rd(8'h54, d, r); `CHK({r, d}, {2'b00, 32'h1})
        imub_host_i.wr(8'h4c, 32'h1, r); `CHK(r, 2'b10)
        imub_host_i.wrs(8'h48, 32'h0, 4'h0, r); `CHK(r, 2'b00)
        imub_host_i.rd(8'h48, d, r); `CHK(d, 32'h80)
        imub_host_i.wr(8'h44, 32'ha5, r);
        imub_host_i.wr(8'h48, 32'h5a, r);
        imub_host_i.rd(8'h44, d, r); `CHK(d, 32'ha5)
        imub_host_i.rd(8'h48, d, r); `CHK(d, 32'h5a)
        imub_host_i.rd(8'h60, d, r); `CHK({r, d}, {2'b10, 32'h0})
        imub_host_i.wr(8'h60, 32'h1, r); `CHK(r, 2'b10)
        RESETN_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        imub_host_i.rd(8'h44, d, r); `CHK(d, 32'h0)
        imub_host_i.rd(8'h48, d, r); `CHK(d, 32'h0)
        `CHK(IRQ_O, 1'b0)
        end_sim;
    end
endmodule
